// ===== verilog/acquisition_ddc_channel.sv
// Purpose: One downconverter channel: source select, NCO mixer, decimating filter.
// Assumes: Input samples are synchronous to i_clock and qualified by i_in_valid.
// Notes:   Instantiate twice for two channels; both may pick the same converter.
// Function
// - Channel input picks converter A, converter B, test signal or loopback.
// - One converter may feed both channels, or each its own.
// - Each channel holds its own 32-bit tuning word, zero up to sample rate.
// - Each channel keeps its own decimation factor.
// - Decimation factor is programmable from 2 to 131072.
// - Filter uses a loadable set of 16-bit user coefficients.
// - A default coefficient set is present after reset.
// - Output is 24-bit I and Q, or 16-bit I and Q by format.
`timescale 1ns/10ps
module acquisition_ddc_channel (
  input  wire logic                           i_clock,
  input  wire logic                           i_rst,
  input  wire logic [ddc_pkg::ADDR_W-1:0]     i_addr,
  input  wire logic [31:0]                    i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [31:0]                    o_rdata,
  input  wire logic [ddc_pkg::SAMP_W-1:0]     i_adc_a,
  input  wire logic [ddc_pkg::SAMP_W-1:0]     i_adc_b,
  input  wire logic [ddc_pkg::SAMP_W-1:0]     i_test,
  input  wire logic [ddc_pkg::SAMP_W-1:0]     i_loop,
  input  wire logic                           i_in_valid,
  output logic      [ddc_pkg::OUT_W-1:0]      o_i,
  output logic      [ddc_pkg::OUT_W-1:0]      o_q,
  output logic                                o_valid
);
  import ddc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Holds a written factor inside the supported range
  function automatic logic [DEC_W-1:0] clamp_decim(input logic [31:0] v);
    if (v < 32'(DEC_MIN)) begin
      return DEC_MIN;
    end else if (v > 32'(DEC_MAX)) begin
      return DEC_MAX;
    end else begin
      return v[DEC_W-1:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [1:0]         src_reg,       src_next;
  logic               fmt16_reg,     fmt16_next;
  logic [5:0]         shift_reg,     shift_next;
  logic [31:0]        tune_reg,      tune_next;
  logic [DEC_W-1:0]   decim_reg,     decim_next;
  logic [COEF_AW-1:0] caddr_reg,     caddr_next;
  logic [COEF_W-1:0]  coef_mem [COEF_N];
  logic [COEF_W-1:0]  coef_next [COEF_N];
  logic [31:0]        rdata_next;
  logic [CNT_W-1:0]   ocount_reg;

  // Register writes, coefficient loading and read mux
  always_comb begin
    src_next   = src_reg;
    fmt16_next = fmt16_reg;
    shift_next = shift_reg;
    tune_next  = tune_reg;
    decim_next = decim_reg;
    caddr_next = caddr_reg;
    coef_next  = coef_mem;
    rdata_next = 32'h0000_0000;
    if (i_wr) begin
      case (i_addr)
        OFF_CTRL: begin
          src_next   = i_wdata[CTRL_SRC_LSB +: 2];
          fmt16_next = i_wdata[CTRL_FMT16_BIT];
          shift_next = i_wdata[CTRL_SHIFT_LSB +: 6];
        end
        OFF_TUNE:      tune_next  = i_wdata;
        OFF_DECIM:     decim_next = clamp_decim(i_wdata);
        OFF_COEF_ADDR: caddr_next = i_wdata[COEF_AW-1:0];
        OFF_COEF_DATA: begin
          coef_next[caddr_reg] = i_wdata[COEF_W-1:0];
          caddr_next           = caddr_reg + 6'h01;
        end
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        OFF_CTRL:      rdata_next = {18'h00000, shift_reg, 5'h00, fmt16_reg, src_reg};
        OFF_TUNE:      rdata_next = tune_reg;
        OFF_DECIM:     rdata_next = {14'h0000, decim_reg};
        OFF_COEF_ADDR: rdata_next = {26'h0000000, caddr_reg};
        OFF_COEF_DATA: rdata_next = {16'h0000, coef_mem[caddr_reg]};
        OFF_STATUS:    rdata_next = {16'h0000, ocount_reg};
        default:       rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Register storage; coefficients load the default set on reset
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      src_reg   <= RST_SRC;
      fmt16_reg <= 1'b0;
      shift_reg <= RST_SHIFT;
      tune_reg  <= RST_TUNE;
      decim_reg <= RST_DECIM;
      caddr_reg <= '0;
      o_rdata   <= 32'h0000_0000;
      for (int k = 0; k < COEF_N; k++) begin
        coef_mem[k] <= RST_COEF;
      end
    end else begin
      src_reg   <= src_next;
      fmt16_reg <= fmt16_next;
      shift_reg <= shift_next;
      tune_reg  <= tune_next;
      decim_reg <= decim_next;
      caddr_reg <= caddr_next;
      o_rdata   <= rdata_next;
      coef_mem  <= coef_next;
    end
  end

  // ----------------------------------------------------------------
  // Datapath: select, mix, accumulate and dump
  // ----------------------------------------------------------------
  logic [SAMP_W-1:0]  samp_reg,   samp_next;
  logic               sv_reg,     sv_next;
  logic [31:0]        phase_reg,  phase_next;
  logic [3:0]         lut_reg,    lut_next;
  logic [OUT_W-1:0]   mi_reg,     mi_next;
  logic [OUT_W-1:0]   mq_reg,     mq_next;
  logic               mv_reg,     mv_next;
  logic [DEC_W-1:0]   cnt_reg,    cnt_next;
  logic [ACC_W-1:0]   acci_reg,   acci_next;
  logic [ACC_W-1:0]   accq_reg,   accq_next;
  logic [OUT_W-1:0]   oi_next,    oq_next;
  logic               ov_next;
  logic [CNT_W-1:0]   ocount_next;
  logic [31:0]        prod_i,     prod_q;
  logic [39:0]        fir_i,      fir_q;
  logic [ACC_W-1:0]   sum_i,      sum_q,    sh_i,   sh_q;
  logic [COEF_W-1:0]  coef_now;

  always_comb begin
    samp_next   = samp_reg;
    sv_next     = i_in_valid;
    phase_next  = phase_reg;
    lut_next    = lut_reg;
    // Input selector
    if (i_in_valid) begin
      case (src_reg)
        SRC_ADC_A: samp_next = i_adc_a;
        SRC_ADC_B: samp_next = i_adc_b;
        SRC_TEST:  samp_next = i_test;
        SRC_LOOP:  samp_next = i_loop;
        default:   samp_next = i_adc_a;
      endcase
      phase_next = phase_reg + tune_reg;
      lut_next   = phase_reg[31:28];
    end
    // Mixer with cosine and negative sine of the current phase
    prod_i  = 32'($signed(samp_reg) * $signed(SIN_LUT[4'(lut_reg + 4'h4)]));
    prod_q  = 32'(-($signed(samp_reg) * $signed(SIN_LUT[lut_reg])));
    mi_next = prod_i[30:7];
    mq_next = prod_q[30:7];
    mv_next = sv_reg;
    // Weighted accumulation over N samples, coefficient by sample index
    coef_now = coef_mem[cnt_reg[COEF_AW-1:0]];
    fir_i    = 40'($signed(mi_reg) * $signed(coef_now));
    fir_q    = 40'($signed(mq_reg) * $signed(coef_now));
    sum_i    = ACC_W'(acci_reg + {{18{fir_i[39]}}, fir_i});
    sum_q    = ACC_W'(accq_reg + {{18{fir_q[39]}}, fir_q});
    sh_i     = ACC_W'($signed(sum_i) >>> shift_reg);
    sh_q     = ACC_W'($signed(sum_q) >>> shift_reg);
    cnt_next    = cnt_reg;
    acci_next   = acci_reg;
    accq_next   = accq_reg;
    ov_next     = 1'b0;
    oi_next     = o_i;
    oq_next     = o_q;
    ocount_next = ocount_reg;
    if (mv_reg) begin
      if (cnt_reg >= decim_reg - 18'h00001) begin
        cnt_next    = '0;
        acci_next   = '0;
        accq_next   = '0;
        ov_next     = 1'b1;
        ocount_next = ocount_reg + 16'h0001;
        if (fmt16_reg) begin
          oi_next = {{8{sh_i[23]}}, sh_i[23:8]};
          oq_next = {{8{sh_q[23]}}, sh_q[23:8]};
        end else begin
          oi_next = sh_i[23:0];
          oq_next = sh_q[23:0];
        end
      end else begin
        cnt_next  = cnt_reg + 18'h00001;
        acci_next = sum_i;
        accq_next = sum_q;
      end
    end
  end

  // Datapath registers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      samp_reg   <= '0;
      sv_reg     <= 1'b0;
      phase_reg  <= '0;
      lut_reg    <= '0;
      mi_reg     <= '0;
      mq_reg     <= '0;
      mv_reg     <= 1'b0;
      cnt_reg    <= '0;
      acci_reg   <= '0;
      accq_reg   <= '0;
      o_i        <= '0;
      o_q        <= '0;
      o_valid    <= 1'b0;
      ocount_reg <= '0;
    end else begin
      samp_reg   <= samp_next;
      sv_reg     <= sv_next;
      phase_reg  <= phase_next;
      lut_reg    <= lut_next;
      mi_reg     <= mi_next;
      mq_reg     <= mq_next;
      mv_reg     <= mv_next;
      cnt_reg    <= cnt_next;
      acci_reg   <= acci_next;
      accq_reg   <= accq_next;
      o_i        <= oi_next;
      o_q        <= oq_next;
      o_valid    <= ov_next;
      ocount_reg <= ocount_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  property p_select;
    i_in_valid && src_reg == SRC_TEST |=> samp_reg == $past(i_test);
  endproperty
  a_select: assert property (p_select) else $error("test source not selected");

  property p_select_b;
    i_in_valid && src_reg == SRC_ADC_B |=> samp_reg == $past(i_adc_b);
  endproperty
  a_select_b: assert property (p_select_b) else $error("converter B not selected");

  property p_tune;
    i_wr && i_addr == OFF_TUNE |=> tune_reg == $past(i_wdata);
  endproperty
  a_tune: assert property (p_tune) else $error("tuning word not stored");

  property p_decim_wr;
    i_wr && i_addr == OFF_DECIM |=> decim_reg == clamp_decim($past(i_wdata));
  endproperty
  a_decim_wr: assert property (p_decim_wr) else $error("decimation not stored");

  property p_decim_range;
    decim_reg >= DEC_MIN && decim_reg <= DEC_MAX;
  endproperty
  a_decim_range: assert property (p_decim_range) else $error("decimation out of range");

  property p_coef;
    i_wr && i_addr == OFF_COEF_DATA |=> coef_mem[$past(caddr_reg)] == $past(i_wdata[15:0]);
  endproperty
  a_coef: assert property (p_coef) else $error("coefficient not loaded");

  property p_fmt16;
    o_valid && $past(fmt16_reg) |-> o_i[23:15] == {9{o_i[15]}} && o_q[23:15] == {9{o_q[15]}};
  endproperty
  a_fmt16: assert property (p_fmt16) else $error("16-bit output not sign extended");

  property p_phase;
    i_in_valid |=> phase_reg == 32'($past(phase_reg) + $past(tune_reg));
  endproperty
  a_phase: assert property (p_phase) else $error("phase step wrong");

  property p_strobe;
    o_valid |-> $past(mv_reg) && $past(cnt_reg) >= $past(decim_reg) - 18'h00001 ##1 !o_valid;
  endproperty
  a_strobe: assert property (p_strobe) else $error("output strobe misplaced");

  c_out24: cover property (o_valid && !fmt16_reg);
  c_out16: cover property (o_valid && fmt16_reg);
  c_loop:  cover property (i_in_valid && src_reg == SRC_LOOP);
endmodule // acquisition_ddc_channel

// ===== verilog/ddc_pkg.sv
// Purpose: Constants for the acquisition downconverter channel.
// Assumes: 100 MHz sample clock, 32-bit register port.
// Notes:   Byte offsets, field positions, reset values and mixer table.
package ddc_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 8;
  localparam int SAMP_W    = 16;
  localparam int OUT_W     = 24;
  localparam int COEF_W    = 16;
  localparam int COEF_AW   = 6;
  localparam int COEF_N    = 64;
  localparam int DEC_W     = 18;
  localparam int ACC_W     = 58;
  localparam int CNT_W     = 16;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_TUNE      = 8'h04;
  localparam logic [7:0] OFF_DECIM     = 8'h08;
  localparam logic [7:0] OFF_COEF_ADDR = 8'h0c;
  localparam logic [7:0] OFF_COEF_DATA = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_SRC_LSB   = 0;
  localparam int CTRL_FMT16_BIT = 2;
  localparam int CTRL_SHIFT_LSB = 8;

  // Source select codes
  localparam logic [1:0] SRC_ADC_A = 2'h0;
  localparam logic [1:0] SRC_ADC_B = 2'h1;
  localparam logic [1:0] SRC_TEST  = 2'h2;
  localparam logic [1:0] SRC_LOOP  = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [1:0]       RST_SRC   = SRC_ADC_A;
  localparam logic [5:0]       RST_SHIFT = 6'h10;
  localparam logic [31:0]      RST_TUNE  = 32'h0000_0000;
  localparam logic [DEC_W-1:0] DEC_MIN   = 18'h00002;
  localparam logic [DEC_W-1:0] DEC_MAX   = 18'h20000;
  localparam logic [DEC_W-1:0] RST_DECIM = 18'h00010;
  localparam logic [COEF_W-1:0] RST_COEF = 16'h4000;

  // Sine table, 16 points over one turn, cosine is a quarter turn ahead
  localparam logic [15:0] SIN_LUT [16] = '{
    16'h0000, 16'h30fb, 16'h5a82, 16'h7641, 16'h7fff, 16'h7641, 16'h5a82, 16'h30fb,
    16'h0000, 16'hcf05, 16'ha57e, 16'h89bf, 16'h8001, 16'h89bf, 16'ha57e, 16'hcf05};
endpackage

// ===== bench/adc_source_model.sv
// Purpose: Converter-side sample source feeding both downconverter channels.
// Assumes: Paced by the bench clock; i_run starts samples, i_slow gives one in three.
// Notes:   Idle cycles show inverted data so that valid gating is exercised.
`timescale 1ns/10ps
module adc_source_model #(
  parameter logic [15:0] LEVEL = 16'h0100
) (
  input  wire logic        i_clock,
  input  wire logic        i_run,
  input  wire logic        i_slow,
  output logic      [15:0] o_adc_a,
  output logic      [15:0] o_adc_b,
  output logic      [15:0] o_test,
  output logic      [15:0] o_loop,
  output logic             o_in_valid
);
  // ----------------------------------------------------------------
  // Sample pacing and source values
  // ----------------------------------------------------------------
  logic [1:0] phase_reg = 2'h0;
  logic       take;

  assign take = i_run && (!i_slow || phase_reg == 2'h0);

  // Values at time zero
  initial begin
    o_in_valid = 1'b0;
    o_adc_a    = 16'h0000;
    o_adc_b    = 16'h0000;
    o_test     = 16'h0000;
    o_loop     = 16'h0000;
  end

  // Converter A and loopback carry +LEVEL, B carries -LEVEL, test is zero
  always @(posedge i_clock) begin
    phase_reg  <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
    o_in_valid <= take;
    o_adc_a    <= take ? LEVEL : ~LEVEL;
    o_adc_b    <= take ? 16'h0000 - LEVEL : LEVEL - 16'h0001;
    o_test     <= take ? 16'h0000 : 16'hffff;
    o_loop     <= take ? LEVEL : ~LEVEL;
  end
endmodule // adc_source_model

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for two downconverter channels on one source.
// Assumes: Read data one cycle after the strobe; output strobe two edges on.
// Notes:   Exact I/Q values are not predicted, only relations between sources.
`timescale 1ns/10ps
module tb_top;
  import ddc_pkg::*;
  logic        i_clock;
  logic        i_rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [1:0]  wr;
  logic [1:0]  rd;
  logic [31:0] rdata [2];
  logic [23:0] oi [2];
  logic [23:0] oq [2];
  logic [1:0]  ov;
  logic [15:0] sa, sb, st, sl;
  logic        in_valid, run, slow, arm;
  logic [3:0]  vd = 4'h0;
  logic [31:0] acc [2] = '{32'h0, 32'h0};
  logic [31:0] exp_n [2] = '{32'h2, 32'h2};
  logic [1:0]  seen = 2'h0;
  int          bad_count = 0;
  int          cmp_count = 0;

  // ----------------------------------------------------------------
  // Clock, source model and two channels on the same source
  // ----------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  adc_source_model adc_source_model_i (.i_clock(i_clock), .i_run(run), .i_slow(slow),
    .o_adc_a(sa), .o_adc_b(sb), .o_test(st), .o_loop(sl), .o_in_valid(in_valid));

  for (genvar c = 0; c < 2; c++) begin : g_ch
    acquisition_ddc_channel acquisition_ddc_channel_i (.i_clock(i_clock), .i_rst(i_rst),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr[c]), .i_rd(rd[c]), .o_rdata(rdata[c]),
      .i_adc_a(sa), .i_adc_b(sb), .i_test(st), .i_loop(sl), .i_in_valid(in_valid),
      .o_i(oi[c]), .o_q(oq[c]), .o_valid(ov[c]));
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input int c, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    addr  <= a;
    wdata <= d;
    wr[c] <= 1'b1;
    @(posedge i_clock);
    wr[c] <= 1'b0;
  endtask

  task automatic rd_chk(input int c, input logic [7:0] a, input logic [31:0] e, input string w);
    @(posedge i_clock);
    addr  <= a;
    rd[c] <= 1'b1;
    @(posedge i_clock);
    rd[c] <= 1'b0;
    #1 chk(w, e, rdata[c]);
  endtask

  // Waits for one output strobe, bounded
  task automatic wait_out(input int c, output logic [23:0] i, output logic [23:0] q);
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (ov[c] !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      bad_count++;
      finish_test();
    end
    i = oi[c];
    q = oq[c];
  endtask

  // Counts accepted samples between strobes, delayed to match the pipeline
  always @(posedge i_clock) begin
    vd <= {vd[2:0], in_valid};
    for (int c = 0; c < 2; c++) begin
      if (ov[c] === 1'b1) begin
        if (arm && seen[c]) chk("samples_per_strobe", exp_n[c], acc[c] + {31'h0, vd[3]});
        seen[c] <= arm;
        acc[c]  <= 32'h0;
      end else begin
        acc[c] <= acc[c] + {31'h0, vd[3]};
        if (!arm) seen[c] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0]  a [7] = '{OFF_CTRL, OFF_TUNE, OFF_DECIM, OFF_COEF_ADDR, OFF_COEF_DATA,
                           OFF_STATUS, 8'h18};
    logic [31:0] e [7] = '{32'h1000, 32'h0, 32'h10, 32'h0, 32'h4000, 32'h0, 32'h0};
    chk("valid_in_reset", 32'h0, {31'h0, ov[0]});
    foreach (a[k]) rd_chk(0, a[k], e[k], "reset_value");
  endtask

  task automatic t_regs();
    logic [31:0] w [4] = '{32'h1, 32'h3ffff, 32'h20000, 32'h2};
    logic [31:0] e [4] = '{32'h2, 32'h20000, 32'h20000, 32'h2};
    wr_reg(0, OFF_TUNE, 32'hffff_ffff);
    rd_chk(0, OFF_TUNE, 32'hffff_ffff, "tune_word");
    rd_chk(1, OFF_TUNE, 32'h0, "other_tune");
    foreach (w[k]) begin
      wr_reg(0, OFF_DECIM, w[k]);
      rd_chk(0, OFF_DECIM, e[k], "decim_clamp");
    end
    wr_reg(0, OFF_COEF_ADDR, 32'h3f);
    wr_reg(0, OFF_COEF_DATA, 32'h1234);
    rd_chk(0, OFF_COEF_ADDR, 32'h0, "coef_addr_wrap");
    wr_reg(0, OFF_COEF_ADDR, 32'h3f);
    rd_chk(0, OFF_COEF_DATA, 32'h1234, "coef_data");
    wr_reg(0, OFF_COEF_DATA, 32'h4000);
    wr_reg(0, OFF_TUNE, 32'h0);
  endtask

  // Both channels on converter A with different factors, fast then slow pace
  task automatic t_rate();
    wr_reg(0, OFF_CTRL, 32'h1400);
    wr_reg(1, OFF_CTRL, 32'h1400);
    wr_reg(1, OFF_DECIM, 32'h5);
    rd_chk(0, OFF_DECIM, 32'h2, "ch0_decim_kept");
    rd_chk(1, OFF_DECIM, 32'h5, "ch1_decim_own");
    exp_n[1] = 32'h5;
    @(posedge i_clock);
    arm <= 1'b1;
    run <= 1'b1;
    repeat (40) @(posedge i_clock);
    slow <= 1'b1;
    repeat (90) @(posedge i_clock);
    run  <= 1'b0;
    slow <= 1'b0;
    arm  <= 1'b0;
    chk("ch1_fed", 32'h1, {31'h0, oi[1] != 24'h0 && oi[1][23] == 1'b0});
  endtask

  task automatic t_route();
    logic [23:0] iv [4];
    logic [23:0] i;
    logic [23:0] q;
    wr_reg(0, OFF_DECIM, 32'h4);
    for (int s = 0; s < 4; s++) begin
      wr_reg(0, OFF_CTRL, 32'h1400 | s);
      run <= 1'b1;
      wait_out(0, i, q);
      wait_out(0, iv[s], q);
      run <= 1'b0;
      chk("q_at_zero_tune", 32'h0, {8'h0, q});
    end
    chk("src_a_positive", 32'h1, {31'h0, iv[0] != 24'h0 && iv[0][23] == 1'b0});
    chk("src_b_negative", 32'h1, {31'h0, iv[1][23]});
    chk("src_test_zero", 32'h0, {8'h0, iv[2]});
    chk("src_loop_same", {8'h0, iv[0]}, {8'h0, iv[3]});
    wr_reg(0, OFF_CTRL, 32'h1404);
    run <= 1'b1;
    wait_out(0, i, q);
    wait_out(0, i, q);
    run <= 1'b0;
    chk("fmt16_i", {8'h0, {8{iv[0][23]}}, iv[0][23:8]}, {8'h0, i});
  endtask

  // Quarter-turn tuning word: Q of successive outputs alternates in sign
  task automatic t_tune();
    logic [23:0] i;
    logic [23:0] q1;
    logic [23:0] q2;
    wr_reg(0, OFF_CTRL, 32'h1400);
    wr_reg(0, OFF_DECIM, 32'h2);
    wr_reg(0, OFF_TUNE, 32'h4000_0000);
    run <= 1'b1;
    wait_out(0, i, q1);
    wait_out(0, i, q1);
    wait_out(0, i, q2);
    run <= 1'b0;
    chk("q_sign_flip", 32'h1, {31'h0, (q1[23] ^ q2[23]) && q1 != 24'h0 && q2 != 24'h0});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    addr  = 8'h00;
    wdata = 32'h0;
    wr    = 2'h0;
    rd    = 2'h0;
    run   = 1'b0;
    slow  = 1'b0;
    arm   = 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset();
    t_regs();
    t_rate();
    t_route();
    t_tune();
    finish_test();
  end
endmodule // tb_top
